// *** tccu_params.svh ***
`ifndef TCCU_PARAMS_SVH
`define TCCU_PARAMS_SVH

// ************************************************************
// register byte addresses (one byte register per word)
// ************************************************************
`define TCCU_ADR_CTRL_A      6'h00
`define TCCU_ADR_CTRL_B      6'h04
`define TCCU_ADR_CMPCTL      6'h08
`define TCCU_ADR_IRQ_EN      6'h0C
`define TCCU_ADR_FLAGS       6'h10
`define TCCU_ADR_CNT_L       6'h14
`define TCCU_ADR_CNT_H       6'h18
`define TCCU_ADR_CAP_L       6'h1C
`define TCCU_ADR_CAP_H       6'h20
`define TCCU_ADR_CMPA_L      6'h24
`define TCCU_ADR_CMPA_H      6'h28
`define TCCU_ADR_CMPB_L      6'h2C
`define TCCU_ADR_CMPB_H      6'h30
`define TCCU_ADR_CMPC_L      6'h34
`define TCCU_ADR_CMPC_H      6'h38

// ************************************************************
// field positions
// ************************************************************
`define TCCU_B_NOISE_EN      7
`define TCCU_B_EDGE_RISE     6
`define TCCU_B_WGM_HI        4
`define TCCU_B_WGM_LO        3
`define TCCU_CMP_CAPSEL      2
`define TCCU_FLG_CAP         5
`define TCCU_FLG_CMPC        3
`define TCCU_FLG_CMPB        2
`define TCCU_FLG_CMPA        1

// ************************************************************
// reset values and timing
// ************************************************************
`define TCCU_RST_BYTE        8'h00
`define TCCU_RST_WORD        16'h0000
`define TCCU_FILT_SAMPLES    4
`define TCCU_MAX_COUNT       16'hFFFF

`endif

// *** tccu_pkg.sv ***
package tccu_pkg;

	typedef logic [15:0] tccu_word_t;
	typedef logic [3:0]  tccu_wgm_t;

	// one classic wishbone request
	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [5:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} tccu_wb_req_s;

	// one classic wishbone answer
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} tccu_wb_rsp_s;

	// how a compare register is updated
	typedef enum logic [1:0] {
		TCCU_UPD_NOW,
		TCCU_UPD_TOP,
		TCCU_UPD_BOTTOM
	} tccu_upd_e;

endpackage : tccu_pkg

// *** tccu_cmp_chan.sv ***
`timescale 1ns/1ns
`include "tccu_params.svh"

// one compare channel: buffer, live register, comparator
module tccu_cmp_chan
	import tccu_pkg::*;
(
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            ce_i,
	input  wire tccu_pkg::tccu_word_t wr_val_i,
	input  wire logic            wr_i,
	input  wire tccu_pkg::tccu_upd_e  upd_i,
	input  wire logic            at_top_i,
	input  wire logic            at_bottom_i,
	input  wire tccu_pkg::tccu_word_t count_i,
	output tccu_pkg::tccu_word_t      sw_val_o,
	output tccu_pkg::tccu_word_t      live_o,
	output logic                 match_o
);

	tccu_word_t buf_q;
	tccu_word_t live_q;

	// ************************************************************
	// buffer and live register
	// ************************************************************
	// software writes the buffer; live copy follows as the mode says
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			buf_q  <= `TCCU_RST_WORD;
			live_q <= `TCCU_RST_WORD;
		end
		else if (ce_i)
		begin
			if (wr_i)
				buf_q <= wr_val_i;
			if (upd_i == TCCU_UPD_NOW && wr_i)
				live_q <= wr_val_i;
			else if ((upd_i == TCCU_UPD_TOP && at_top_i) ||
				(upd_i == TCCU_UPD_BOTTOM && at_bottom_i))
				live_q <= buf_q;
		end
	end

	// software sees the buffer when buffered, else the live copy
	assign sw_val_o = (upd_i == TCCU_UPD_NOW) ? live_q : buf_q;
	assign live_o   = live_q;
	// continuous 16-bit equality
	assign match_o  = (count_i == live_q);

endmodule : tccu_cmp_chan

// *** tccu_top.sv ***
`timescale 1ns/1ns
`include "tccu_params.svh"

module tccu_top
	import tccu_pkg::*;
(
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 ce_i,
	input  wire tccu_pkg::tccu_wb_req_s wb_req_i,
	output tccu_pkg::tccu_wb_rsp_s      wb_rsp_o,
	input  wire logic                 capture_input_pin_i,
	input  wire logic                 comparator_output_i,
	input  wire logic                 timer_tick_i,
	input  wire logic [2:0]           irq_ack_i,
	output logic [2:0]                match_o,
	output logic                      at_top_o,
	output logic                      at_bottom_o,
	output logic                      capture_irq_o,
	output logic                      compare_irq_o
);
	import tccu_pkg::*;

	// waveform modes whose top comes from the capture register
	function automatic logic cap_is_top(input tccu_wgm_t m);
		cap_is_top = (m == 4'hC) || (m == 4'hE) || (m == 4'h8) || (m == 4'hA);
	endfunction : cap_is_top

	// waveform modes whose top comes from channel A
	function automatic logic cmpa_is_top(input tccu_wgm_t m);
		cmpa_is_top = (m == 4'h4) || (m == 4'hF) || (m == 4'h9) || (m == 4'hB);
	endfunction : cmpa_is_top

	// compare update policy per waveform mode
	function automatic tccu_upd_e upd_of(input tccu_wgm_t m);
		if (m == 4'h0 || m == 4'h4 || m == 4'hC || m == 4'hD)
			upd_of = TCCU_UPD_NOW;
		else if (m == 4'h8 || m == 4'h9)
			upd_of = TCCU_UPD_BOTTOM;
		else
			upd_of = TCCU_UPD_TOP;
	endfunction : upd_of

	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0]  ctrl_a_q;
	logic [7:0]  timer_control_b_q;
	logic [7:0]  comparator_control_status_q;
	logic [7:0]  irq_en_q;
	logic [7:0]  temp_q;
	tccu_word_t  counter_value_q;
	tccu_word_t  capture_register_q;
	logic        capture_flag_q;
	logic [2:0]  compare_flag_q;
	logic        cnt_wr_block_q;
	logic        ack_q;
	logic [31:0] rdat_q;
	logic        sync1_q;
	logic        sync2_q;
	logic        sync3_q;
	logic [2:0]  filt_sh_q;
	logic        filt_q;
	logic        filt_prev_q;

	tccu_wgm_t   waveform_mode_field;
	tccu_upd_e   upd;
	tccu_word_t  top_val;
	tccu_word_t  cmp_sw [3];
	tccu_word_t  cmp_live [3];
	logic [2:0]  cmp_eq;
	logic [2:0]  cmp_wr;
	logic        bus_go;
	logic        wr_go;
	logic        rd_go;
	logic [5:0]  adr;
	logic [7:0]  wbyte;
	logic        cap_src;
	logic        edge_in;
	logic        cap_evt;
	logic        is_top;
	logic        is_bot;

	assign waveform_mode_field = {timer_control_b_q[`TCCU_B_WGM_HI:`TCCU_B_WGM_LO],
		ctrl_a_q[1:0]};
	assign upd   = upd_of(waveform_mode_field);
	assign bus_go = wb_req_i.cyc && wb_req_i.stb && !ack_q && ce_i;
	assign wr_go = bus_go && wb_req_i.we && wb_req_i.sel[0];
	assign rd_go = bus_go && !wb_req_i.we;
	assign adr   = wb_req_i.adr;
	assign wbyte = wb_req_i.dat[7:0];

	// top follows capture register or channel A, else full scale
	assign top_val = cap_is_top(waveform_mode_field) ? capture_register_q :
		cmpa_is_top(waveform_mode_field) ? cmp_live[0] : `TCCU_MAX_COUNT;
	assign is_top = (counter_value_q == top_val);
	assign is_bot = (counter_value_q == `TCCU_RST_WORD);

	// ************************************************************
	// compare channels
	// ************************************************************
	assign cmp_wr[0] = wr_go && adr == `TCCU_ADR_CMPA_L;
	assign cmp_wr[1] = wr_go && adr == `TCCU_ADR_CMPB_L;
	assign cmp_wr[2] = wr_go && adr == `TCCU_ADR_CMPC_L;

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_ch
			tccu_cmp_chan u_ch (
				.clk_i      (clk_i),
				.rst_i      (rst_i),
				.ce_i       (ce_i),
				.wr_val_i   ({temp_q, wbyte}),
				.wr_i       (cmp_wr[g]),
				.upd_i      (upd),
				.at_top_i   (is_top && timer_tick_i),
				.at_bottom_i(is_bot && timer_tick_i),
				.count_i    (counter_value_q),
				.sw_val_o   (cmp_sw[g]),
				.live_o     (cmp_live[g]),
				.match_o    (cmp_eq[g])
			);
		end
	endgenerate

	// ************************************************************
	// capture input path
	// ************************************************************
	// source select; pin value includes software-driven port level
	assign cap_src = comparator_control_status_q[`TCCU_CMP_CAPSEL] ?
		comparator_output_i : capture_input_pin_i;

	// two-stage synchroniser plus a sample for the edge detector
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end
		else if (ce_i)
		begin
			sync1_q <= cap_src;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// filter: newest sample plus three stored ones must agree, so a
	// clean edge reaches the detector exactly four cycles late
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			filt_sh_q <= 3'h0;
			filt_q    <= 1'b0;
		end
		else if (ce_i)
		begin
			filt_sh_q <= {filt_sh_q[1:0], sync3_q};
			if (&{filt_sh_q, sync3_q})
				filt_q <= 1'b1;
			else if (~|{filt_sh_q, sync3_q})
				filt_q <= 1'b0;
		end
	end

	// filtered level costs four extra cycles when enabled
	assign edge_in = timer_control_b_q[`TCCU_B_NOISE_EN] ? filt_q : sync3_q;

	// edge detect; disabled when the capture register sets top
	assign cap_evt = !cap_is_top(waveform_mode_field) &&
		(timer_control_b_q[`TCCU_B_EDGE_RISE] ? (edge_in && !filt_prev_q) :
		(!edge_in && filt_prev_q));

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			filt_prev_q <= 1'b0;
		else if (ce_i)
			filt_prev_q <= edge_in;
	end

	// ************************************************************
	// counter value (software load, tick driven count)
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			counter_value_q <= `TCCU_RST_WORD;
		else if (ce_i)
		begin
			if (wr_go && adr == `TCCU_ADR_CNT_L)
				counter_value_q <= {temp_q, wbyte}; // cpu write wins
			else if (timer_tick_i)
				counter_value_q <= is_top ? `TCCU_RST_WORD : counter_value_q + 16'h0001;
		end
	end

	// block armed by a counter write, spent on the next tick
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cnt_wr_block_q <= 1'b0;
		else if (ce_i)
		begin
			if (wr_go && (adr == `TCCU_ADR_CNT_L))
				cnt_wr_block_q <= 1'b1;
			else if (timer_tick_i)
				cnt_wr_block_q <= 1'b0;
		end
	end

	// ************************************************************
	// capture register and flags
	// ************************************************************
	// latest event always overwrites; no overrun protection
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			capture_register_q <= `TCCU_RST_WORD;
		else if (ce_i)
		begin
			if (cap_evt)
				capture_register_q <= counter_value_q;
			else if (wr_go && adr == `TCCU_ADR_CAP_L && cap_is_top(waveform_mode_field))
				capture_register_q <= {temp_q, wbyte};
		end
	end

	// set wins over software or service clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			capture_flag_q <= 1'b0;
			compare_flag_q <= 3'h0;
		end
		else if (ce_i)
		begin
			if (cap_evt)
				capture_flag_q <= 1'b1;
			else if (irq_ack_i[0] || (wr_go && adr == `TCCU_ADR_FLAGS &&
				wbyte[`TCCU_FLG_CAP]))
				capture_flag_q <= 1'b0;
			for (int i = 0; i < 3; i++)
			begin
				if (timer_tick_i && cmp_eq[i] && !cnt_wr_block_q)
					compare_flag_q[i] <= 1'b1;
				else if ((irq_ack_i[1] && i == 0) || (irq_ack_i[2] && i != 0) ||
					(wr_go && adr == `TCCU_ADR_FLAGS && wbyte[`TCCU_FLG_CMPA + i]))
					compare_flag_q[i] <= 1'b0;
			end
		end
	end

	// ************************************************************
	// control registers and shared temporary byte
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_a_q                    <= `TCCU_RST_BYTE;
			timer_control_b_q           <= `TCCU_RST_BYTE;
			comparator_control_status_q <= `TCCU_RST_BYTE;
			irq_en_q                    <= `TCCU_RST_BYTE;
			temp_q                      <= `TCCU_RST_BYTE;
		end
		else if (ce_i)
		begin
			if (wr_go)
			begin
				case (adr)
					`TCCU_ADR_CTRL_A: ctrl_a_q <= wbyte;
					`TCCU_ADR_CTRL_B: timer_control_b_q <= wbyte;
					`TCCU_ADR_CMPCTL: comparator_control_status_q <= wbyte;
					`TCCU_ADR_IRQ_EN: irq_en_q <= wbyte;
					`TCCU_ADR_CNT_H, `TCCU_ADR_CAP_H, `TCCU_ADR_CMPA_H,
					`TCCU_ADR_CMPB_H, `TCCU_ADR_CMPC_H: temp_q <= wbyte;
					default: ;
				endcase
			end
			else if (rd_go && adr == `TCCU_ADR_CAP_L)
				temp_q <= capture_register_q[15:8];
			else if (rd_go && adr == `TCCU_ADR_CNT_L)
				temp_q <= counter_value_q[15:8];
		end
	end

	// ************************************************************
	// wishbone answer: one wait state, unmapped reads zero
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h00000000;
		end
		else if (ce_i)
		begin
			ack_q  <= bus_go;
			rdat_q <= 32'h00000000;
			if (rd_go)
			begin
				case (adr)
					`TCCU_ADR_CTRL_A: rdat_q[7:0] <= ctrl_a_q;
					`TCCU_ADR_CTRL_B: rdat_q[7:0] <= timer_control_b_q;
					`TCCU_ADR_CMPCTL: rdat_q[7:0] <= comparator_control_status_q;
					`TCCU_ADR_IRQ_EN: rdat_q[7:0] <= irq_en_q;
					`TCCU_ADR_FLAGS:  rdat_q[7:0] <= {2'b00, capture_flag_q, 1'b0,
						compare_flag_q[2:1], compare_flag_q[0], 1'b0};
					`TCCU_ADR_CNT_L:  rdat_q[7:0] <= counter_value_q[7:0];
					`TCCU_ADR_CNT_H:  rdat_q[7:0] <= temp_q;
					`TCCU_ADR_CAP_L:  rdat_q[7:0] <= capture_register_q[7:0];
					`TCCU_ADR_CAP_H:  rdat_q[7:0] <= temp_q;
					`TCCU_ADR_CMPA_L: rdat_q[7:0] <= cmp_sw[0][7:0];
					`TCCU_ADR_CMPA_H: rdat_q[7:0] <= cmp_sw[0][15:8];
					`TCCU_ADR_CMPB_L: rdat_q[7:0] <= cmp_sw[1][7:0];
					`TCCU_ADR_CMPB_H: rdat_q[7:0] <= cmp_sw[1][15:8];
					`TCCU_ADR_CMPC_L: rdat_q[7:0] <= cmp_sw[2][7:0];
					`TCCU_ADR_CMPC_H: rdat_q[7:0] <= cmp_sw[2][15:8];
					default:          rdat_q <= 32'h00000000;
				endcase
			end
		end
	end

	assign wb_rsp_o.ack = ack_q;
	assign wb_rsp_o.dat = rdat_q;

	// ************************************************************
	// registered outputs to waveform generator and interrupts
	// ************************************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			match_o       <= 3'h0;
			at_top_o      <= 1'b0;
			at_bottom_o   <= 1'b0;
			capture_irq_o <= 1'b0;
			compare_irq_o <= 1'b0;
		end
		else if (ce_i)
		begin
			match_o       <= cmp_eq & {3{!cnt_wr_block_q}};
			at_top_o      <= is_top;
			at_bottom_o   <= is_bot;
			capture_irq_o <= capture_flag_q && irq_en_q[`TCCU_FLG_CAP];
			compare_irq_o <= |(compare_flag_q & irq_en_q[3:1]);
		end
	end

endmodule : tccu_top

// *** tccu_checker.sv ***
`timescale 1ns/1ns

// ********
// bus and output timing checks
// ********
module tccu_checker
	import tccu_pkg::*;
(
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  ce_i,
	input wire tccu_pkg::tccu_wb_req_s wb_req_i,
	input wire tccu_pkg::tccu_wb_rsp_s wb_rsp_o,
	input wire logic                  capture_input_pin_i,
	input wire logic                  comparator_output_i,
	input wire logic                  timer_tick_i,
	input wire logic [2:0]            irq_ack_i,
	input wire logic [2:0]            match_o,
	input wire logic                  at_top_o,
	input wire logic                  at_bottom_o,
	input wire logic                  capture_irq_o,
	input wire logic                  compare_irq_o
);
	import tccu_pkg::*;
	// a take is a request seen while no answer stands
	logic take;
	assign take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && ce_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_taken: assert property (take |=> wb_rsp_o.ack)
		else $error("bus request not answered after one cycle");
	a_ack_single: assert property (wb_rsp_o.ack && ce_i |=> !wb_rsp_o.ack)
		else $error("bus answer longer than one cycle");
	a_ack_cause: assert property (!(wb_req_i.cyc && wb_req_i.stb) && ce_i |=> !wb_rsp_o.ack)
		else $error("bus answer without request");
	a_unmapped_zero: assert property (take && !wb_req_i.we && wb_req_i.adr == 6'h3C
		|=> wb_rsp_o.ack && wb_rsp_o.dat == 32'h0)
		else $error("unmapped read not zero");
	a_dat_pad: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h0)
		else $error("read data above low byte not zero");
	// a frozen enable must hold every output, the answer too
	a_freeze_all: assert property (!ce_i |=> $stable(wb_rsp_o) && $stable(match_o)
		&& $stable({at_top_o, at_bottom_o, capture_irq_o, compare_irq_o}))
		else $error("outputs moved while clock enable low");
	// match and extremes move only after a count, a write or a reset
	a_match_cause: assert property ($changed({match_o, at_top_o, at_bottom_o}) |->
		$past(rst_i) || $past(rst_i, 2) || $past(timer_tick_i) || $past(timer_tick_i, 2)
		|| $past(wb_rsp_o.ack) || $past(wb_rsp_o.ack, 2))
		else $error("match output changed without cause");
	a_cirq_cause: assert property ($rose(compare_irq_o) |->
		$past(timer_tick_i, 2) || $past(timer_tick_i, 3) || $past(wb_rsp_o.ack)
		|| $past(wb_rsp_o.ack, 2))
		else $error("compare interrupt raised without cause");
endmodule : tccu_checker

// *** tccu_sig_model.sv ***
`timescale 1ns/1ns

// ********
// external event source on the capture pin
// ********
module tccu_sig_model
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       go_i,
	input  wire logic [7:0] len_i,
	output logic            pin_o
);
	logic [7:0] cnt_q;
	// high pulse of len_i cycles; short ones model noise glitches
	always_ff @(posedge clk_i)
	begin
		if (rst_i || (!go_i && cnt_q <= 8'h01))
		begin
			pin_o <= 1'b0;
			cnt_q <= 8'h00;
		end
		else if (go_i)
		begin
			pin_o <= 1'b1;
			cnt_q <= len_i;
		end
		else
			cnt_q <= cnt_q - 8'h01;
	end
endmodule : tccu_sig_model

// *** tb_top.sv ***
`timescale 1ns/1ns
`include "tccu_params.svh"

// ********
// bench signals and helpers
// ********
module tb_top;
	import tccu_pkg::*;
	logic         clk_i, rst_i, ce_i, pin, cmp, tick, go;
	logic [7:0]   len, q;
	logic [2:0]   irq_ack, match;
	logic         at_top, at_bot, cap_irq, cmp_irq;
	tccu_wb_req_s req;
	tccu_wb_rsp_s rsp;
	int           err_total, tests_run, n, n1, n2;
	int           cyc_n = 0;
	// rows: write flag, address, write data, expected read data
	logic [22:0]  rows [22] = '{
		{1'b0, `TCCU_ADR_CTRL_A, 16'h0000}, {1'b0, `TCCU_ADR_CTRL_B, 16'h0000},
		{1'b0, `TCCU_ADR_CMPCTL, 16'h0000}, {1'b0, `TCCU_ADR_IRQ_EN, 16'h0000},
		{1'b0, `TCCU_ADR_FLAGS, 16'h0000}, {1'b0, `TCCU_ADR_CNT_L, 16'h0000},
		{1'b0, `TCCU_ADR_CAP_L, 16'h0000}, {1'b0, `TCCU_ADR_CMPA_H, 16'h0000},
		{1'b0, `TCCU_ADR_CMPC_L, 16'h0000},
		{1'b1, `TCCU_ADR_CNT_H, 16'h1200}, {1'b1, `TCCU_ADR_CNT_L, 16'h3400},
		{1'b0, `TCCU_ADR_CNT_L, 16'h0034}, {1'b0, `TCCU_ADR_CNT_H, 16'h0012},
		{1'b1, `TCCU_ADR_CMPA_H, 16'h0000}, {1'b1, `TCCU_ADR_CMPA_L, 16'h4000},
		{1'b1, `TCCU_ADR_CMPB_H, 16'hAB00}, {1'b1, `TCCU_ADR_CMPB_L, 16'hCD00},
		{1'b0, `TCCU_ADR_CNT_L, 16'h0034}, {1'b0, `TCCU_ADR_CMPB_H, 16'h00AB},
		{1'b0, `TCCU_ADR_CMPB_L, 16'h00CD},
		{1'b1, 6'h3C, 16'h5500}, {1'b0, 6'h3C, 16'h0000}};

	tccu_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(req), .wb_rsp_o(rsp),
		.capture_input_pin_i(pin), .comparator_output_i(cmp), .timer_tick_i(tick),
		.irq_ack_i(irq_ack), .match_o(match), .at_top_o(at_top), .at_bottom_o(at_bot),
		.capture_irq_o(cap_irq), .compare_irq_o(cmp_irq));
	tccu_sig_model u_sig (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .len_i(len), .pin_o(pin));

	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clk_i)
	begin
		cyc_n++;
		if (cyc_n > 8000)
		begin
			err_total++;
			stop_test();
		end
	end

	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task stop_test;
		$display("mismatches %0d, comparisons %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	// one classic cycle; request held until ack is sampled high
	task wb(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] r);
		int k;
		k = 0;
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
		// no limit here: only the hang guard ends a missing answer
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (rsp.ack !== 1'b1);
		chk(16'(k), 16'd2);
		r = rsp.dat[7:0];
		req <= '0;
	endtask : wb

	task wr(input logic [5:0] a, input logic [7:0] d);
		wb(1'b1, a, d, q);
	endtask : wr

	task rc(input logic [5:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00, q);
		chk({8'h00, q}, {8'h00, e});
	endtask : rc

	task tk;
		@(posedge clk_i);
		tick <= 1'b1;
		@(posedge clk_i);
		tick <= 1'b0;
	endtask : tk

	// rising event from pin or comparator; n is cycles to interrupt, 40 if none
	task lat(input logic s, input logic [7:0] l, input logic [7:0] e, output int n);
		@(posedge clk_i);
		cmp <= s;
		go <= !s;
		len <= l;
		@(posedge clk_i);
		go <= 1'b0;
		for (n = 0; n < 40 && cap_irq !== 1'b1; n++)
			@(posedge clk_i);
		cmp <= 1'b0;
		rc(`TCCU_ADR_FLAGS, e);
		irq_ack <= 3'b001;
		@(posedge clk_i);
		irq_ack <= 3'b000;
		rc(`TCCU_ADR_FLAGS, 8'h00);
		repeat (8) @(posedge clk_i);
	endtask : lat

	// ********
	// main sequence
	// ********
	initial
	begin
		rst_i = 1'b1;
		ce_i = 1'b1;
		{cmp, tick, go, len, irq_ack, req, err_total, tests_run} = '0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i])
		begin
			wb(rows[i][22], rows[i][21:16], rows[i][15:8], q);
			if (!rows[i][22])
				chk({8'h00, q}, {8'h00, rows[i][7:0]});
		end
		// capture with interrupts off, then overwrite with them on
		wr(`TCCU_ADR_CTRL_B, 8'h40);
		lat(1'b0, 8'h08, 8'h20, n);
		chk(16'(n), 16'd40);
		rc(`TCCU_ADR_CAP_L, 8'h34);
		rc(`TCCU_ADR_CAP_H, 8'h12);
		wr(`TCCU_ADR_CNT_H, 8'h56);
		wr(`TCCU_ADR_CNT_L, 8'h78);
		wr(`TCCU_ADR_IRQ_EN, 8'h20);
		lat(1'b0, 8'h08, 8'h20, n1);
		chk(16'(n1 < 40), 16'h0001);
		rc(`TCCU_ADR_CAP_L, 8'h78);
		rc(`TCCU_ADR_CAP_H, 8'h56);
		// source switch while the comparator is high, then clear by writing one
		cmp <= 1'b1;
		wr(`TCCU_ADR_CMPCTL, 8'h04);
		repeat (8) @(posedge clk_i);
		rc(`TCCU_ADR_FLAGS, 8'h20);
		wr(`TCCU_ADR_FLAGS, 8'h20);
		rc(`TCCU_ADR_FLAGS, 8'h00);
		cmp <= 1'b0;
		repeat (8) @(posedge clk_i);
		lat(1'b1, 8'h08, 8'h20, n);
		chk(16'(n < 40), 16'h0001);
		lat(1'b0, 8'h08, 8'h00, n);
		chk(16'(n), 16'd40);
		wr(`TCCU_ADR_CMPCTL, 8'h00);
		// filter: glitch rejected, long pulse four cycles later
		wr(`TCCU_ADR_CTRL_B, 8'hC0);
		lat(1'b0, 8'h02, 8'h00, n);
		chk(16'(n), 16'd40);
		lat(1'b0, 8'h08, 8'h20, n2);
		chk(16'(n2 - n1), 16'd4);
		// capture-as-top mode 12 ignores events
		wr(`TCCU_ADR_CTRL_B, 8'h58);
		lat(1'b0, 8'h08, 8'h00, n);
		chk(16'(n), 16'd40);
		wr(`TCCU_ADR_CTRL_B, 8'h40);
		// compare A at 0x0040 in normal mode: flag one tick after match
		wr(`TCCU_ADR_IRQ_EN, 8'h02);
		wr(`TCCU_ADR_CNT_H, 8'h00);
		wr(`TCCU_ADR_CNT_L, 8'h3E);
		tk();
		tk();
		repeat (2) @(posedge clk_i);
		chk({15'h0, match[0]}, 16'h0001);
		rc(`TCCU_ADR_FLAGS, 8'h00);
		tk();
		rc(`TCCU_ADR_FLAGS, 8'h02);
		chk({15'h0, cmp_irq}, 16'h0001);
		irq_ack <= 3'b010;
		@(posedge clk_i);
		irq_ack <= 3'b000;
		rc(`TCCU_ADR_FLAGS, 8'h00);
		// counter written equal to compare: next-tick match blocked
		wr(`TCCU_ADR_CNT_H, 8'h00);
		wr(`TCCU_ADR_CNT_L, 8'h40);
		repeat (2) @(posedge clk_i);
		chk({15'h0, match[0]}, 16'h0000);
		tk();
		rc(`TCCU_ADR_FLAGS, 8'h00);
		// fast pwm mode 5: compare B write goes to the buffer only
		wr(`TCCU_ADR_CTRL_A, 8'h01);
		wr(`TCCU_ADR_CTRL_B, 8'h48);
		wr(`TCCU_ADR_CMPB_H, 8'h00);
		wr(`TCCU_ADR_CMPB_L, 8'h42);
		rc(`TCCU_ADR_CMPB_L, 8'h42);
		tk();
		repeat (2) @(posedge clk_i);
		chk({15'h0, match[1]}, 16'h0000);
		// ctc mode 4: channel A is top; a tick under a frozen enable is lost
		wr(`TCCU_ADR_CTRL_A, 8'h00);
		wr(`TCCU_ADR_CNT_H, 8'h00);
		wr(`TCCU_ADR_CNT_L, 8'h40);
		ce_i <= 1'b0;
		tk();
		ce_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({14'h0, at_top, at_bot}, 16'h0002);
		tk();
		repeat (2) @(posedge clk_i);
		chk({14'h0, at_top, at_bot}, 16'h0001);
		// reset in mid-run: enables and compare values back to zero
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(`TCCU_ADR_IRQ_EN, 8'h00);
		rc(`TCCU_ADR_CMPA_L, 8'h00);
		chk({14'h0, at_top, at_bot}, 16'h0001);
		stop_test();
	end
endmodule : tb_top

bind tccu_top tccu_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .capture_input_pin_i(capture_input_pin_i),
	.comparator_output_i(comparator_output_i), .timer_tick_i(timer_tick_i),
	.irq_ack_i(irq_ack_i), .match_o(match_o), .at_top_o(at_top_o),
	.at_bottom_o(at_bottom_o), .capture_irq_o(capture_irq_o), .compare_irq_o(compare_irq_o));
